//--- rtl/pin_ctrl_pkg.sv
package pin_ctrl_pkg;

    // ****************************************
    // Register offsets (byte addresses).
    // ****************************************
    localparam logic [7:0] OFF_CTRL      = 8'h00;
    localparam logic [7:0] OFF_STEP      = 8'h04;
    localparam logic [7:0] OFF_NUMERATOR = 8'h08;
    localparam logic [7:0] OFF_STATUS    = 8'h0C;

    // ****************************************
    // Control register fields.
    // ****************************************
    localparam int CTRL_DCO_EN    = 0;
    localparam int CTRL_PIN_EN    = 1;
    localparam int CTRL_SYNC_SW   = 2;
    localparam int CTRL_MANUAL    = 3;
    localparam int CTRL_REFPIN_EN = 4;
    localparam int CTRL_WIDTH     = 5;
    localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 5'h00;

    // ****************************************
    // Widths, addresses and timing.
    // ****************************************
    localparam int          NUM_WIDTH     = 32;
    localparam logic [31:0] STEP_RESET    = 32'h0000_0001;
    localparam logic [31:0] NUM_RESET     = 32'h0000_0000;
    localparam logic [4:0]  ADDR_UPPER    = 5'h19;
    localparam int          POR_TIME_NS   = 1000;
    localparam int          CLK_PERIOD_NS = 50;
    localparam int          POR_CYCLES    = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ****************************************
    // Reference choices and sequencing phases.
    // ****************************************
    localparam logic [1:0] REF_PRIMARY   = 2'h0;
    localparam logic [1:0] REF_AUTO      = 2'h1;
    localparam logic [1:0] REF_SECONDARY = 2'h2;

    typedef enum logic [2:0] {
        ST_DOWN = 3'h1,
        ST_POR  = 3'h2,
        ST_RUN  = 3'h4
    } phase_t;

endpackage : pin_ctrl_pkg

//--- rtl/pin_sync3.sv
`timescale 1ns/10ps

// Three-stage synchroniser; a change is accepted once stages two and three agree.
module pin_sync3 #(
    parameter int        WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    // Clock and reset.
    input  wire logic             clk,
    input  wire logic             rstn,
    // Data.
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] out;
    } sync_state_t;

    sync_state_t state_reg;
    sync_state_t state_next;

    // Shift the stages and update the filtered output bit by bit when stable.
    always_comb begin
        state_next    = state_reg;
        state_next.s1 = async_in;
        state_next.s2 = state_reg.s1;
        state_next.s3 = state_reg.s2;
        for (int i = 0; i < WIDTH; i++) begin
            if (state_reg.s2[i] == state_reg.s3[i]) begin
                state_next.out[i] = state_reg.s3[i];
            end
        end
    end

    // Register all stages.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_reg <= {INIT, INIT, INIT, INIT};
        end else begin
            state_reg <= state_next;
        end
    end

    assign sync_out = state_reg.out;

endmodule : pin_sync3

//--- rtl/clock_sync_pin_ctrl.sv
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps

module clock_sync_pin_ctrl
    import pin_ctrl_pkg::*;
#(
    parameter int POR_LEN = POR_CYCLES
) (
    // Clock and reset.
    input  wire logic        CLK,
    input  wire logic        RSTN,
    // APB slave.
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // Device pins.
    input  wire logic        CHIP_POWERDOWN_INPUT_N,
    input  wire logic        STARTUP_MODE_SELECT,
    input  wire logic        OUTPUT_SYNC_INPUT_N,
    input  wire logic [1:0]  ADDRESS_LSB_SELECT,
    input  wire logic        DCO_STEP_UP_INPUT,
    input  wire logic        DCO_STEP_DOWN_INPUT,
    input  wire logic [1:0]  REFERENCE_SELECT,
    // Results.
    output logic             SERIAL_ENABLE,
    output logic [6:0]       TARGET_ADDRESS,
    output logic             STARTUP_MODE,
    output logic             OUTPUTS_MUTED,
    output logic             DIVIDER_RESET,
    output logic [1:0]       ACTIVE_REFERENCE,
    output logic [31:0]      DCO_NUMERATOR
);

    // ****************************************
    // Pin synchronisers.
    // ****************************************
    logic [8:0] pins_sync;

    // The mode strap is a pin too, so it passes the same filter as the others.
    pin_sync3 #(
        .WIDTH (9),
        .INIT  (9'h002)
    ) u_sync (
        .clk      (CLK),
        .rstn     (RSTN),
        .async_in ({STARTUP_MODE_SELECT, REFERENCE_SELECT, DCO_STEP_DOWN_INPUT,
                    DCO_STEP_UP_INPUT, ADDRESS_LSB_SELECT, OUTPUT_SYNC_INPUT_N,
                    CHIP_POWERDOWN_INPUT_N}),
        .sync_out (pins_sync)
    );

    logic       pdn_s;
    logic       sync_n_s;
    logic [1:0] addr_s;
    logic       up_s;
    logic       down_s;
    logic [1:0] ref_s;
    logic       mode_s;

    assign pdn_s    = pins_sync[0];
    assign sync_n_s = pins_sync[1];
    assign addr_s   = pins_sync[3:2];
    assign up_s     = pins_sync[4];
    assign down_s   = pins_sync[5];
    assign ref_s    = pins_sync[7:6];
    assign mode_s   = pins_sync[8];

    // ****************************************
    // State.
    // ****************************************
    typedef struct packed {
        phase_t                phase;
        logic [15:0]           por_cnt;
        logic                  mode;
        logic [1:0]            addr_lsb;
        logic [CTRL_WIDTH-1:0] ctrl;
        logic [31:0]           step;
        logic [31:0]           num;
        logic                  up_prev;
        logic                  down_prev;
        logic [31:0]           rdata;
    } top_state_t;

    top_state_t state_reg;
    top_state_t state_next;

    function automatic logic [31:0] read_mux(input top_state_t s, input logic [7:0] a);
        case (a)
            OFF_CTRL:      read_mux = {27'h0, s.ctrl};
            OFF_STEP:      read_mux = s.step;
            OFF_NUMERATOR: read_mux = s.num;
            OFF_STATUS:    read_mux = {24'h0, s.addr_lsb, s.mode, 2'h0, s.phase};
            default:       read_mux = 32'h0000_0000;
        endcase
    endfunction : read_mux

    function automatic logic known_addr(input logic [7:0] a);
        known_addr = (a == OFF_CTRL) || (a == OFF_STEP) || (a == OFF_NUMERATOR) ||
                     (a == OFF_STATUS);
    endfunction : known_addr

    logic access;
    logic up_edge;
    logic down_edge;
    logic pins_on;

    assign access    = PSEL && PENABLE;
    assign up_edge   = up_s && !state_reg.up_prev;
    assign down_edge = down_s && !state_reg.down_prev;
    assign pins_on   = state_reg.ctrl[CTRL_DCO_EN] && state_reg.ctrl[CTRL_PIN_EN];

    // Sequencing, register access and numerator stepping.
    always_comb begin
        state_next           = state_reg;
        state_next.up_prev   = up_s;
        state_next.down_prev = down_s;
        case (state_reg.phase)
            ST_DOWN: begin
                if (pdn_s) begin
                    state_next.phase   = ST_POR;
                    state_next.por_cnt = 16'h0000;
                end
            end
            ST_POR: begin
                // Straps are caught here only; later pin changes are ignored.
                state_next.mode     = mode_s;
                state_next.addr_lsb = addr_s;
                state_next.ctrl     = CTRL_RESET;
                state_next.step     = STEP_RESET;
                state_next.num      = NUM_RESET;
                state_next.por_cnt  = state_reg.por_cnt + 16'h0001;
                if (state_reg.por_cnt >= 16'(POR_LEN - 1)) begin
                    state_next.phase = ST_RUN;
                end
            end
            ST_RUN: begin
                if (access && PWRITE) begin
                    case (PADDR)
                        OFF_CTRL:      state_next.ctrl = PWDATA[CTRL_WIDTH-1:0];
                        OFF_STEP:      state_next.step = PWDATA;
                        OFF_NUMERATOR: state_next.num  = PWDATA;
                        default:       state_next.ctrl = state_reg.ctrl;
                    endcase
                end
                // Pulses win over a simultaneous numerator write.
                if (pins_on && up_edge && !down_edge) begin
                    state_next.num = state_reg.num + state_reg.step;
                end else if (pins_on && down_edge && !up_edge) begin
                    state_next.num = state_reg.num - state_reg.step;
                end
            end
            default: state_next.phase = ST_DOWN;
        endcase
        state_next.rdata = read_mux(state_reg, PADDR);
        // Power-down low dominates every phase.
        if (!pdn_s) begin
            state_next.phase = ST_DOWN;
        end
    end

    // Register the whole state.
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            state_reg <= '{phase: ST_DOWN, por_cnt: 16'h0000, mode: 1'b0, addr_lsb: 2'h0,
                           ctrl: CTRL_RESET, step: STEP_RESET, num: NUM_RESET,
                           up_prev: 1'b0, down_prev: 1'b0, rdata: 32'h0000_0000};
        end else begin
            state_reg <= state_next;
        end
    end

    // ****************************************
    // Bus answers: one-cycle access, zero wait states.
    // ****************************************
    assign PREADY  = 1'b1;
    assign PSLVERR = access && (!known_addr(PADDR) || state_reg.phase != ST_RUN);
    // Read data is caught in the setup cycle, so the bus sees a flip-flop output.
    assign PRDATA  = state_reg.rdata;

    // ****************************************
    // Outputs.
    // ****************************************
    logic running;
    logic sync_on;
    assign running = state_reg.phase == ST_RUN;
    // Sync pin is active low; the register bit is an alternative trigger.
    assign sync_on = !sync_n_s || state_reg.ctrl[CTRL_SYNC_SW];

    assign SERIAL_ENABLE    = running;
    assign TARGET_ADDRESS   = {ADDR_UPPER, state_reg.addr_lsb};
    assign STARTUP_MODE     = state_reg.mode;
    assign OUTPUTS_MUTED    = !running || sync_on;
    assign DIVIDER_RESET    = !running || sync_on;
    assign ACTIVE_REFERENCE = (state_reg.ctrl[CTRL_MANUAL] && state_reg.ctrl[CTRL_REFPIN_EN])
                              ? ref_s : REF_AUTO;
    assign DCO_NUMERATOR    = state_reg.num;

endmodule : clock_sync_pin_ctrl

//--- tb/pin_ctrl_properties.sv
`timescale 1ns/10ps
// ****************************************
// Port checker for the pin control block.
// ****************************************
module pin_ctrl_properties
    import pin_ctrl_pkg::*;
#(
    parameter int POR_LEN = 4
) (
    // Clock, reset and bus.
    input wire logic        CLK,
    input wire logic        RSTN,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PRDATA,
    input wire logic        PSLVERR,
    // Pins and results.
    input wire logic        CHIP_POWERDOWN_INPUT_N,
    input wire logic        OUTPUT_SYNC_INPUT_N,
    input wire logic        DCO_STEP_UP_INPUT,
    input wire logic        DCO_STEP_DOWN_INPUT,
    input wire logic        SERIAL_ENABLE,
    input wire logic [6:0]  TARGET_ADDRESS,
    input wire logic        OUTPUTS_MUTED,
    input wire logic        DIVIDER_RESET,
    input wire logic [31:0] DCO_NUMERATOR
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);
    // Six cycles cover the pin synchroniser, so the off state must show by then.
    serial_off_a: assert property (!CHIP_POWERDOWN_INPUT_N [*6] |-> !SERIAL_ENABLE)
        else $error("serial side on while powered down");
    muted_down_a: assert property (!SERIAL_ENABLE && $past(!SERIAL_ENABLE)
        |-> OUTPUTS_MUTED && DIVIDER_RESET) else $error("outputs live outside run");
    sync_mute_a: assert property (!OUTPUT_SYNC_INPUT_N [*6]
        |-> OUTPUTS_MUTED && DIVIDER_RESET) else $error("sync low but outputs live");
    addr_upper_a: assert property (TARGET_ADDRESS[6:2] == ADDR_UPPER)
        else $error("upper address bits wrong");
    addr_stable_a: assert property (SERIAL_ENABLE && $past(SERIAL_ENABLE)
        |-> $stable(TARGET_ADDRESS)) else $error("address moved while running");
    num_hold_a: assert property ((!DCO_STEP_UP_INPUT && !DCO_STEP_DOWN_INPUT) [*8]
        ##0 (SERIAL_ENABLE && $past(SERIAL_ENABLE) && !$past(PSEL && PENABLE && PWRITE))
        |-> $stable(DCO_NUMERATOR)) else $error("numerator moved without a pulse");
    bus_off_a: assert property (PSEL && PENABLE && !SERIAL_ENABLE |-> PSLVERR)
        else $error("access accepted outside run");
    unmapped_a: assert property (PSEL && PENABLE && PADDR > OFF_STATUS
        |-> PSLVERR && PRDATA == 32'h0) else $error("unmapped access accepted");
    // Filter delay plus one cycle to leave power-down, then the sequence length itself.
    por_time_a: assert property ($rose(SERIAL_ENABLE)
        |-> $past(CHIP_POWERDOWN_INPUT_N, POR_LEN + 5)
        && !$past(CHIP_POWERDOWN_INPUT_N, POR_LEN + 6)) else $error("sequence length wrong");
    run_c: cover property ($rose(SERIAL_ENABLE));
    step_c: cover property (SERIAL_ENABLE && $changed(DCO_NUMERATOR));
    err_c: cover property (PSEL && PENABLE && PSLVERR && SERIAL_ENABLE);
endmodule : pin_ctrl_properties

bind clock_sync_pin_ctrl pin_ctrl_properties #(.POR_LEN(POR_LEN)) props_i (.*);

//--- tb/host_pins_model.sv
`timescale 1ns/10ps
// ****************************************
// Host side of the logic pins.
// ****************************************
module host_pins_model (
    // Clock.
    input wire logic CLK,
    // Pins driven towards the device.
    output logic     pwr_ok,
    output logic     sync_n,
    output logic     up,
    output logic     down
);
    // Start powered down with sync released, so reset begins from a known state.
    initial begin
        pwr_ok = 1'b0;
        sync_n = 1'b1;
        up     = 1'b0;
        down   = 1'b0;
    end
    // Level pins change just after an edge.
    task set_power(input logic v);
        @(posedge CLK);
        pwr_ok <= v;
    endtask : set_power
    task set_sync(input logic v);
        @(posedge CLK);
        sync_n <= v;
    endtask : set_sync
    // Discrete low-high-low pulse; the long low tail lets the synchroniser settle.
    task pulse(input logic dir);
        @(posedge CLK);
        if (dir) begin
            up <= 1'b1;
        end else begin
            down <= 1'b1;
        end
        repeat (2) @(posedge CLK);
        up   <= 1'b0;
        down <= 1'b0;
        repeat (8) @(posedge CLK);
    endtask : pulse
endmodule : host_pins_model

//--- tb/clock_sync_pin_ctrl_bench.sv
`timescale 1ns/10ps
// ****************************************
// Self-checking bench for the pin control block.
// ****************************************
module clock_sync_pin_ctrl_bench import pin_ctrl_pkg::*;;
    logic        CLK = 1'b0, RSTN, psel, penable, pwrite;
    logic        mode_sel, err, pready, pslverr, serial_en, mode, muted, div_rst;
    logic        pwr_ok, sync_n, up, down, dir, exp_mode;
    logic [1:0]  addr_sel, ref_sel, act_ref;
    logic [6:0]  target;
    logic [7:0]  paddr;
    logic [31:0] pwdata, rdata, prdata, num, step, exp_num, seed = 32'hBAD059F6;
    int          error_cnt = 0, compares = 0, cycles = 0;

    clock_sync_pin_ctrl #(.POR_LEN(4)) clock_sync_pin_ctrl_i (.CLK(CLK), .RSTN(RSTN),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .CHIP_POWERDOWN_INPUT_N(pwr_ok), .STARTUP_MODE_SELECT(mode_sel),
        .OUTPUT_SYNC_INPUT_N(sync_n), .ADDRESS_LSB_SELECT(addr_sel), .DCO_STEP_UP_INPUT(up),
        .DCO_STEP_DOWN_INPUT(down), .REFERENCE_SELECT(ref_sel), .SERIAL_ENABLE(serial_en),
        .TARGET_ADDRESS(target), .STARTUP_MODE(mode), .OUTPUTS_MUTED(muted),
        .DIVIDER_RESET(div_rst), .ACTIVE_REFERENCE(act_ref), .DCO_NUMERATOR(num));
    host_pins_model host_pins_model_i (.CLK(CLK), .pwr_ok(pwr_ok), .sync_n(sync_n),
        .up(up), .down(down));

    // Clock and a hang guard; the run needs a few hundred cycles at most.
    always #25 CLK = ~CLK;
    always @(posedge CLK) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            error_cnt++;
            results();
        end
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task results;
        $display("mismatches %0d, compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : results
    // One APB transfer; the trailing idle cycle keeps drivers from clashing.
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge CLK);
        penable <= 1'b1;
        do @(posedge CLK); while (pready !== 1'b1);
        rdata = prdata;
        err   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge CLK);
    endtask : apb
    task por(input logic [1:0] lsb, input logic m);
        host_pins_model_i.set_power(1'b0);
        addr_sel <= lsb;
        mode_sel <= m;
        repeat (8) @(posedge CLK);
        chk(serial_en, 1'b0);
        host_pins_model_i.set_power(1'b1);
        for (int n = 0; n < 60 && serial_en !== 1'b1; n++) @(posedge CLK);
    endtask : por

    // Main sequence: address LSBs 0, 1 and 2 in turn, random mode straps, data and pulse directions.
    initial begin
        RSTN     <= 1'b0;
        psel     <= 1'b0;
        penable  <= 1'b0;
        pwrite   <= 1'b0;
        paddr    <= 8'h00;
        pwdata   <= 32'h0;
        mode_sel <= 1'b0;
        addr_sel <= 2'h0;
        ref_sel  <= 2'h0;
        repeat (6) @(posedge CLK);
        RSTN <= 1'b1;
        repeat (10) @(posedge CLK);
        chk(muted, 1'b1);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk(err, 1'b1);
        for (int i = 0; i < 3; i++) begin
            seed     = lfsr(seed);
            exp_mode = seed[0];
            por(i[1:0], exp_mode);
            chk(serial_en, 1'b1);
            chk(target, {ADDR_UPPER, i[1:0]});
            chk(mode, exp_mode);
            apb(1'b0, OFF_CTRL, 32'h0);
            chk(rdata, CTRL_RESET);
            apb(1'b0, OFF_NUMERATOR, 32'h0);
            chk(rdata, NUM_RESET);
            apb(1'b0, OFF_STEP, 32'h0);
            chk(rdata, STEP_RESET);
            apb(1'b0, OFF_STATUS, 32'h0);
            chk(rdata, {24'h0, i[1:0], exp_mode, 2'h0, ST_RUN});
            addr_sel <= ~i[1:0];
            mode_sel <= ~exp_mode;
            repeat (8) @(posedge CLK);
            chk({mode, target}, {exp_mode, ADDR_UPPER, i[1:0]});
            seed = lfsr(seed);
            apb(1'b1, OFF_NUMERATOR, seed);
            apb(1'b1, OFF_CTRL, 32'h1F);
        end
        seed    = lfsr(seed);
        step    = {16'h0, seed[15:0]};
        exp_num = seed;
        apb(1'b1, OFF_CTRL, 32'h0);
        apb(1'b1, OFF_STEP, step);
        apb(1'b1, OFF_NUMERATOR, exp_num);
        host_pins_model_i.pulse(1'b1);
        chk(num, exp_num);
        apb(1'b1, OFF_CTRL, 32'h3);
        for (int k = 0; k < 6; k++) begin
            seed = lfsr(seed);
            dir  = seed[3];
            host_pins_model_i.pulse(dir);
            exp_num = dir ? exp_num + step : exp_num - step;
            chk(num, exp_num);
        end
        host_pins_model_i.set_sync(1'b0);
        repeat (6) @(posedge CLK);
        chk({muted, div_rst}, 2'h3);
        host_pins_model_i.set_sync(1'b1);
        repeat (6) @(posedge CLK);
        chk({muted, div_rst}, 2'h0);
        apb(1'b1, OFF_CTRL, 32'h7);
        repeat (2) @(posedge CLK);
        chk({muted, div_rst}, 2'h3);
        for (int j = 0; j < 3; j++) begin
            ref_sel <= j[1:0];
            apb(1'b1, OFF_CTRL, 32'h18);
            repeat (6) @(posedge CLK);
            chk(act_ref, j[1:0]);
            apb(1'b1, OFF_CTRL, 32'h0);
            // A random pin level must still be ignored in automatic mode.
            seed    = lfsr(seed);
            ref_sel <= seed[5:4];
            repeat (6) @(posedge CLK);
            chk({muted, act_ref}, {1'b0, REF_AUTO});
        end
        apb(1'b0, 8'h10, 32'h0);
        chk({err, rdata}, {1'b1, 32'h0});
        results();
    end
endmodule : clock_sync_pin_ctrl_bench
